// *** logic/gpcs_core.sv ***
// Contract
// - read-only ident word: 4-bit revision high, 12-bit device code low.
// - writing one to control word one bit 15 resets all; self-clears.
// - two output-pin mode selectors at 14:12 and 11:9, reset 110.
// - io pin one selector loads 100 if collision low, out pin one high.
// - io pins two and three selectors at 5:3 and 2:0, reset 000.
// - control word two holds io pins seven..four selectors, reset 000.
// - bit 13 picks edge for pins four..seven flags; 0 falling.
// - bit 12 picks edge for pins one..three flags; 0 falling.
// - each io pin has a flag set by its edge, cleared by read.
// - status low bits show each io pin's live level, reset zero.
// - mode selectors can route the combined interrupt onto a pin.
module gpcs_core #(
	parameter logic [3:0] REVISION = 4'h1, // arbitrary value
	parameter logic [11:0] DEVICE_CODE = 12'h5a5, // arbitrary value
	parameter int SYNC_STAGES = 2
)(
	// clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register access
	input wire gpcs_pkg::gpcs_reg_req_type reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// bidirectional pins
	input wire logic [6:0] io_in,
	output logic [6:0] io_out,
	output logic [6:0] io_oe_n,
	// output-only pins
	output logic [1:0] out_pin,
	output logic [1:0] out_oe_n,
	// strap pins
	input wire logic col_pin,
	input wire logic out_pin1_strap,
	// sources for pin modes
	input wire logic irq_req,
	input wire logic ref_clk_lvl,
	// device reset request
	output logic soft_rst_out
);
	import gpcs_pkg::*;

	if (SYNC_STAGES < 2) begin : g_chk
		$error("gpcs_core needs at least two sync stages");
	end

	function automatic logic hit(input gpcs_reg_req_type r,
		input logic [3:0] ofs);
		return r.addr == ofs;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [6:0] io_lvl;
	logic [6:0] io_rise;
	logic [6:0] io_fall;
	logic [1:0] strap_lvl;

	gpcs_sync #(
		.WIDTH(GPCS_IO_PINS),
		.STAGES(SYNC_STAGES)
	) u_io_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in(io_in),
		.level(io_lvl),
		.rise(io_rise),
		.fall(io_fall)
	);

	gpcs_sync #(
		.WIDTH(2),
		.STAGES(SYNC_STAGES)
	) u_strap_sync (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({out_pin1_strap, col_pin}),
		.level(strap_lvl),
		.rise(),
		.fall()
	);

	////////////////////////////////////////////////////////////////////////
	// control, strap and status state

	gpcs_ctl_type ctl_reg;
	gpcs_ctl_type ctl_next;
	logic [1:0] strap_cnt_reg;
	logic [1:0] strap_cnt_next;
	logic [6:0] flag_reg;
	logic [6:0] flag_next;
	logic [6:0] level_reg;
	logic [6:0] level_next;
	logic soft_rst_reg;
	logic soft_rst_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;

	logic wr_ctl1;
	logic wr_ctl2;
	logic rd_stat;
	logic do_reset;
	logic [6:0] evt;
	logic [15:0] ctl1_word;
	logic [15:0] ctl2_word;
	logic [15:0] stat_word;
	logic [15:0] ident_word;

	always_comb begin
		wr_ctl1 = reg_req.wr && hit(reg_req, GPCS_OFS_CTL1);
		wr_ctl2 = reg_req.wr && hit(reg_req, GPCS_OFS_CTL2);
		rd_stat = reg_req.rd && hit(reg_req, GPCS_OFS_STAT);
		do_reset = wr_ctl1 && reg_req.wdata[GPCS_CTL1_RST];
		for (int i = 0; i < GPCS_IO_PINS; i++) begin
			if (i < GPCS_LOWER_GROUP) begin
				evt[i] = ctl_reg.pol_lower ? io_rise[i] : io_fall[i];
			end else begin
				evt[i] = ctl_reg.pol_upper ? io_rise[i] : io_fall[i];
			end
		end
	end

	// word images
	always_comb begin
		ident_word = '0;
		ident_word[GPCS_IDENT_REVISION_LSB +: 4] = REVISION;
		ident_word[GPCS_IDENT_DEV_LSB +: 12] = DEVICE_CODE;
		ctl1_word = '0;
		ctl1_word[GPCS_CTL1_OUT1_LSB +: 3] = ctl_reg.out_sel[0];
		ctl1_word[GPCS_CTL1_OUT2_LSB +: 3] = ctl_reg.out_sel[1];
		ctl1_word[GPCS_CTL1_IO1_LSB +: 3] = ctl_reg.io_sel[0];
		ctl1_word[GPCS_CTL1_IO2_LSB +: 3] = ctl_reg.io_sel[1];
		ctl1_word[GPCS_CTL1_IO3_LSB +: 3] = ctl_reg.io_sel[2];
		ctl2_word = '0;
		ctl2_word[GPCS_CTL2_POL_UPPER] = ctl_reg.pol_upper;
		ctl2_word[GPCS_CTL2_POL_LOWER] = ctl_reg.pol_lower;
		for (int i = 0; i < 4; i++) begin
			ctl2_word[GPCS_CTL2_IO4_LSB + 3*i +: 3] = ctl_reg.io_sel[3+i];
		end
		stat_word = '0;
		stat_word[GPCS_STAT_FLAG_LSB +: 7] = flag_reg;
		stat_word[GPCS_STAT_LEVEL_LSB +: 7] = level_reg;
	end

	// control registers and strap load
	always_comb begin
		ctl_next = ctl_reg;
		strap_cnt_next = strap_cnt_reg;
		soft_rst_next = 1'b0;
		if (clk_en) begin
			if (strap_cnt_reg != 2'h0) begin
				strap_cnt_next = strap_cnt_reg - 2'h1;
			end
			if (strap_cnt_reg == 2'h1) begin
				// strap_lvl[0] collision, strap_lvl[1] out pin one
				ctl_next.io_sel[0] = (!strap_lvl[0] && strap_lvl[1]) ?
					GPCS_STRAP_CLK_SEL : GPCS_RST_IO_SEL;
			end
			if (do_reset) begin
				ctl_next.out_sel = {GPCS_RST_OUT_SEL, GPCS_RST_OUT_SEL};
				ctl_next.io_sel = '0;
				ctl_next.pol_upper = GPCS_RST_POL;
				ctl_next.pol_lower = GPCS_RST_POL;
				strap_cnt_next = GPCS_STRAP_WAIT;
				soft_rst_next = 1'b1;
			end else if (wr_ctl1) begin
				ctl_next.out_sel[0] =
					reg_req.wdata[GPCS_CTL1_OUT1_LSB +: 3];
				ctl_next.out_sel[1] =
					reg_req.wdata[GPCS_CTL1_OUT2_LSB +: 3];
				ctl_next.io_sel[0] = reg_req.wdata[GPCS_CTL1_IO1_LSB +: 3];
				ctl_next.io_sel[1] =
					reg_req.wdata[GPCS_CTL1_IO2_LSB +: 3];
				ctl_next.io_sel[2] =
					reg_req.wdata[GPCS_CTL1_IO3_LSB +: 3];
			end else if (wr_ctl2) begin
				ctl_next.pol_upper =
					reg_req.wdata[GPCS_CTL2_POL_UPPER];
				ctl_next.pol_lower =
					reg_req.wdata[GPCS_CTL2_POL_LOWER];
				for (int i = 0; i < 4; i++) begin
					ctl_next.io_sel[3+i] =
						reg_req.wdata[GPCS_CTL2_IO4_LSB + 3*i +: 3];
				end
			end
		end
	end

	// latched flags and live levels
	always_comb begin
		flag_next = flag_reg;
		level_next = level_reg;
		if (clk_en) begin
			level_next = io_lvl;
			if (do_reset) begin
				flag_next = '0;
			end else begin
				// set beats the read-clear
				flag_next = (flag_reg & ~{7{rd_stat}}) | evt;
			end
		end
	end

	// read port
	always_comb begin
		rdata_next = rdata_reg;
		rvalid_next = rvalid_reg;
		if (clk_en) begin
			rvalid_next = reg_req.rd;
			rdata_next = '0;
			if (reg_req.rd) begin
				case (reg_req.addr)
					GPCS_OFS_IDENT: rdata_next = ident_word;
					GPCS_OFS_CTL1: rdata_next = ctl1_word;
					GPCS_OFS_CTL2: rdata_next = ctl2_word;
					GPCS_OFS_STAT: rdata_next = stat_word;
					default: rdata_next = '0;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctl_reg.out_sel <= {GPCS_RST_OUT_SEL, GPCS_RST_OUT_SEL};
			ctl_reg.io_sel <= '0;
			ctl_reg.pol_upper <= GPCS_RST_POL;
			ctl_reg.pol_lower <= GPCS_RST_POL;
			strap_cnt_reg <= GPCS_STRAP_WAIT;
			flag_reg <= '0;
			level_reg <= '0;
			soft_rst_reg <= 1'b0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end else begin
			ctl_reg <= ctl_next;
			strap_cnt_reg <= strap_cnt_next;
			flag_reg <= flag_next;
			level_reg <= level_next;
			soft_rst_reg <= soft_rst_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	logic [8:0][2:0] drv_mode;
	logic [8:0] drv_out;
	logic [8:0] drv_oe_n;
	logic strap_busy;

	assign drv_mode = {ctl_reg.out_sel, ctl_reg.io_sel};
	// pads released while straps are being sampled
	assign strap_busy = strap_cnt_reg != 2'h0;

	for (genvar g = 0; g < 9; g++) begin : g_drv
		gpcs_pin_drive u_drv (
			.mclk(mclk),
			.sys_rst(sys_rst),
			.clk_en(clk_en),
			.mode(drv_mode[g]),
			.hold(strap_busy),
			.irq(irq_req),
			.ref_lvl(ref_clk_lvl),
			.pin_out(drv_out[g]),
			.pin_oe_n(drv_oe_n[g])
		);
	end

	assign io_out = drv_out[6:0];
	assign io_oe_n = drv_oe_n[6:0];
	assign out_pin = drv_out[8:7];
	assign out_oe_n = drv_oe_n[8:7];
	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign soft_rst_out = soft_rst_reg;

endmodule

// *** logic/gpcs_pin_drive.sv ***
module gpcs_pin_drive (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// mode and sources
	input wire logic [2:0] mode,
	input wire logic hold,
	input wire logic irq,
	input wire logic ref_lvl,
	// pad
	output logic pin_out,
	output logic pin_oe_n
);
	import gpcs_pkg::*;

	logic out_reg;
	logic out_next;
	logic oe_n_reg;
	logic oe_n_next;

	// returns {oe_n, level} for a mode code
	function automatic logic [1:0] decode(input logic [2:0] m,
		input logic q, input logic r);
		logic [1:0] res;
		res = 2'h2;
		case (m)
			GPCS_MODE_HIZ: res = 2'h2;
			GPCS_MODE_LOW, GPCS_MODE_LOW_ALT: res = 2'h0;
			GPCS_MODE_HIGH, GPCS_MODE_HIGH_ALT: res = 2'h1;
			GPCS_MODE_IRQ_OD: res = q ? 2'h0 : 2'h2;
			GPCS_MODE_REFCLK: res = {1'b0, r};
			GPCS_MODE_IRQ_PP: res = {1'b0, q};
			default: res = 2'h2;
		endcase
		return res;
	endfunction

	always_comb begin
		out_next = out_reg;
		oe_n_next = oe_n_reg;
		if (clk_en) begin
			{oe_n_next, out_next} = hold ? 2'h2 : decode(mode, irq, ref_lvl);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			out_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			out_reg <= out_next;
			oe_n_reg <= oe_n_next;
		end
	end

	assign pin_out = out_reg;
	assign pin_oe_n = oe_n_reg;

endmodule

// *** logic/gpcs_pkg.sv ***
package gpcs_pkg;

	// register offsets
	localparam logic [3:0] GPCS_OFS_IDENT = 4'h0;
	localparam logic [3:0] GPCS_OFS_CTL1 = 4'h1;
	localparam logic [3:0] GPCS_OFS_CTL2 = 4'h2;
	localparam logic [3:0] GPCS_OFS_STAT = 4'h3;

	// field positions, first control word
	localparam int GPCS_CTL1_RST = 15;
	localparam int GPCS_CTL1_OUT1_LSB = 12;
	localparam int GPCS_CTL1_OUT2_LSB = 9;
	localparam int GPCS_CTL1_IO1_LSB = 6;
	localparam int GPCS_CTL1_IO2_LSB = 3;
	localparam int GPCS_CTL1_IO3_LSB = 0;

	// field positions, second control word
	localparam int GPCS_CTL2_POL_UPPER = 13;
	localparam int GPCS_CTL2_POL_LOWER = 12;
	localparam int GPCS_CTL2_IO4_LSB = 0;

	// field positions, status and identification words
	localparam int GPCS_STAT_FLAG_LSB = 8;
	localparam int GPCS_STAT_LEVEL_LSB = 0;
	localparam int GPCS_IDENT_REVISION_LSB = 12;
	localparam int GPCS_IDENT_DEV_LSB = 0;

	// pin counts
	localparam int GPCS_IO_PINS = 7;
	localparam int GPCS_OUT_PINS = 2;
	localparam int GPCS_LOWER_GROUP = 3;

	// values after reset
	localparam logic [2:0] GPCS_RST_OUT_SEL = 3'h6;
	localparam logic [2:0] GPCS_RST_IO_SEL = 3'h0;
	localparam logic [2:0] GPCS_STRAP_CLK_SEL = 3'h4;
	localparam logic GPCS_RST_POL = 1'h0;

	// mode selector codes
	localparam logic [2:0] GPCS_MODE_HIZ = 3'h0;
	localparam logic [2:0] GPCS_MODE_LOW = 3'h1;
	localparam logic [2:0] GPCS_MODE_HIGH = 3'h2;
	localparam logic [2:0] GPCS_MODE_IRQ_OD = 3'h3;
	localparam logic [2:0] GPCS_MODE_REFCLK = 3'h4;
	localparam logic [2:0] GPCS_MODE_IRQ_PP = 3'h5;
	localparam logic [2:0] GPCS_MODE_LOW_ALT = 3'h6;
	localparam logic [2:0] GPCS_MODE_HIGH_ALT = 3'h7;

	// cycles from reset release until straps are taken
	localparam logic [1:0] GPCS_STRAP_WAIT = 2'h3;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [15:0] wdata;
	} gpcs_reg_req_type;

	typedef struct packed {
		logic [1:0][2:0] out_sel;
		logic [6:0][2:0] io_sel;
		logic pol_upper;
		logic pol_lower;
	} gpcs_ctl_type;

endpackage

// *** logic/gpcs_sync.sv ***
module gpcs_sync #(
	parameter int WIDTH = 7,
	parameter int STAGES = 2
)(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// asynchronous levels
	input wire logic [WIDTH-1:0] async_in,
	// synchronised level and edges
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);
	import gpcs_pkg::*;

	if (STAGES < 2) begin : g_chk
		$error("gpcs_sync needs at least two stages");
	end

	logic [STAGES-1:0][WIDTH-1:0] stage_reg;
	logic [STAGES-1:0][WIDTH-1:0] stage_next;
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] prev_next;

	always_comb begin
		stage_next = stage_reg;
		prev_next = prev_reg;
		if (clk_en) begin
			stage_next = {stage_reg[STAGES-2:0], async_in};
			prev_next = stage_reg[STAGES-1];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			stage_reg <= '0;
			prev_reg <= '0;
		end else begin
			stage_reg <= stage_next;
			prev_reg <= prev_next;
		end
	end

	assign level = stage_reg[STAGES-1];
	assign rise = stage_reg[STAGES-1] & ~prev_reg;
	assign fall = ~stage_reg[STAGES-1] & prev_reg;

endmodule

// *** verif/gpcs_core_asserts.sv ***
module gpcs_core_asserts
	import gpcs_pkg::*;
#(
	parameter logic [3:0] REVISION = 4'h1,
	parameter logic [11:0] DEVICE_CODE = 12'h5a5
)(
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// register access
	input wire gpcs_pkg::gpcs_reg_req_type reg_req,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	// pads and reset request
	input wire logic [6:0] io_oe_n,
	input wire logic [1:0] out_oe_n,
	input wire logic soft_rst_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	logic rd_ok;
	logic [3:0] ad;
	assign rd_ok = reg_req.rd && clk_en;
	assign ad = reg_req.addr;
	////////////////////////////////////////////////////////////////////
	a_read_answer: assert property (rd_ok |=> reg_rvalid)
		else $error("read not answered");
	a_stray_answer: assert property (reg_rvalid |-> $past(rd_ok))
		else $error("answer without read");
	a_idle_rdata: assert property (!reg_rvalid |-> reg_rdata == 16'h0)
		else $error("read data not zero when idle");
	a_ident_word: assert property (rd_ok && ad == GPCS_OFS_IDENT
		|=> reg_rdata == {REVISION, DEVICE_CODE})
		else $error("identification word wrong");
	a_unmapped_zero: assert property (rd_ok && ad > 4'h3
		|=> reg_rdata == 16'h0)
		else $error("unmapped read not zero");
	a_rst_bit_clear: assert property (rd_ok && ad == GPCS_OFS_CTL1
		|=> !reg_rdata[15])
		else $error("reset bit reads one");
	a_soft_rst_pulse: assert property (reg_req.wr && clk_en
		&& ad == GPCS_OFS_CTL1 && reg_req.wdata[15]
		|=> soft_rst_out ##1 !soft_rst_out)
		else $error("reset request pulse wrong");
	a_stat_reserved: assert property (rd_ok && ad == GPCS_OFS_STAT
		|=> !reg_rdata[15] && !reg_rdata[7])
		else $error("status reserved bits set");
	a_ctl2_reserved: assert property (rd_ok && ad == GPCS_OFS_CTL2
		|=> reg_rdata[15:14] == 2'h0)
		else $error("control two reserved bits set");
	a_pads_released: assert property ($fell(sys_rst)
		|-> (&io_oe_n && &out_oe_n)[*3])
		else $error("pads driven during strap wait");
	cover property (rd_ok && ad == GPCS_OFS_STAT);
	cover property (soft_rst_out);
	cover property (reg_rvalid && reg_rdata[14:8] != 7'h0);
endmodule

bind gpcs_core gpcs_core_asserts #(
	.REVISION(REVISION),
	.DEVICE_CODE(DEVICE_CODE)
) gpcs_core_asserts_inst (.mclk, .sys_rst, .clk_en, .reg_req, .reg_rdata,
	.reg_rvalid, .io_oe_n, .out_oe_n, .soft_rst_out);

// *** verif/gpcs_core_tb.sv ***
module gpcs_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import gpcs_pkg::*;
	logic mclk, sys_rst, col_pin, strap1, irq_req, reg_rvalid, soft_rst_out;
	logic clk_en, ref_lvl;
	gpcs_reg_req_type reg_req;
	logic [15:0] reg_rdata;
	logic [6:0] io_in, io_out, io_oe_n, ext_lvl;
	logic [1:0] out_pin, out_oe_n;
	int miscompares, checked;

	gpcs_core gpcs_core_inst (.mclk, .sys_rst, .clk_en, .reg_req,
		.reg_rdata, .reg_rvalid, .io_in, .io_out, .io_oe_n, .out_pin,
		.out_oe_n, .col_pin, .out_pin1_strap(strap1), .irq_req,
		.ref_clk_lvl(ref_lvl), .soft_rst_out);
	gpcs_pin_model gpcs_pin_model_inst (.io_out, .io_oe_n, .ext_lvl, .io_in);
	////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("mismatches %0d checks %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_req <= '{1'b0, 1'b1, a, d};
		@(posedge mclk);
		reg_req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_req <= '{1'b1, 1'b0, a, 16'h0};
		@(posedge mclk);
		reg_req <= '0;
		#1;
		chk({15'h0, reg_rvalid}, 16'h0001);
		chk(reg_rdata, exp);
	endtask
	task automatic pins(input logic [6:0] v);
		@(posedge mclk);
		ext_lvl <= v;
		repeat (8) @(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		repeat (8) @(posedge mclk);
		rd(4'h0, 16'h15a5);
		rd(4'h1, 16'h6d00);
		rd(4'h2, 16'h0000);
		// strapped pin one forwards the reference level
		@(posedge mclk);
		ref_lvl <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({14'h0, io_out[0], io_oe_n[0]}, 16'h0002);
		ref_lvl <= 1'b0;
		repeat (6) @(posedge mclk);
		rd(4'h3, 16'h0100);
		rd(4'h3, 16'h0000);
		wr(4'h1, 16'h6c00);
	endtask
	task automatic t_fields();
		wr(4'h2, 16'hf249);
		rd(4'h2, 16'h3249);
		wr(4'h0, 16'hffff);
		rd(4'h0, 16'h15a5);
		rd(4'h9, 16'h0000);
		wr(4'h3, 16'hffff);
		rd(4'h3, 16'h0000);
		wr(4'h2, 16'h0000);
	endtask
	task automatic t_edges();
		pins(7'h7f);
		rd(4'h3, 16'h007f);
		wr(4'h2, 16'h3000);
		pins(7'h00);
		rd(4'h3, 16'h0000);
		pins(7'h7f);
		rd(4'h3, 16'h7f7f);
		rd(4'h3, 16'h007f);
		wr(4'h2, 16'h2000);
		// falling edge lands in the cycle of a status read
		@(posedge mclk);
		ext_lvl <= 7'h00;
		@(posedge mclk);
		rd(4'h3, 16'h007f);
		rd(4'h3, 16'h0700);
	endtask
	task automatic t_irq();
		wr(4'h1, 16'h6c28);
		irq_req <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({14'h0, io_out[1], io_oe_n[1]}, 16'h0002);
		irq_req <= 1'b0;
		repeat (8) @(posedge mclk);
		chk({14'h0, io_out[1], io_oe_n[1]}, 16'h0000);
		rd(4'h3, 16'h0200);
		// out pins drive high, pin one open-drain interrupt
		wr(4'h1, 16'h74c0);
		irq_req <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({12'h0, out_pin, out_oe_n}, 16'h000c);
		chk({14'h0, io_out[0], io_oe_n[0]}, 16'h0000);
		irq_req <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({14'h0, io_out[0], io_oe_n[0]}, 16'h0001);
	endtask
	task automatic t_soft();
		col_pin <= 1'b1;
		wr(4'h2, 16'h3249);
		wr(4'h1, 16'h8000);
		#1;
		chk({15'h0, soft_rst_out}, 16'h0001);
		repeat (8) @(posedge mclk);
		rd(4'h2, 16'h0000);
		rd(4'h1, 16'h6c00);
	endtask
	task automatic t_freeze();
		// a write while frozen is not taken
		@(posedge mclk);
		clk_en <= 1'b0;
		wr(4'h2, 16'h0249);
		@(posedge mclk);
		clk_en <= 1'b1;
		rd(4'h2, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end
	initial begin
		sys_rst = 1'b1;
		reg_req = '0;
		col_pin = 1'b0;
		strap1 = 1'b1;
		irq_req = 1'b0;
		clk_en = 1'b1;
		ref_lvl = 1'b0;
		ext_lvl = 7'h00;
		miscompares = 0;
		checked = 0;
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_fields();
		t_edges();
		t_irq();
		t_soft();
		t_freeze();
		wrap_up();
	end
endmodule

// *** verif/gpcs_pin_model.sv ***
module gpcs_pin_model (
	// design pad drive
	input wire logic [6:0] io_out,
	input wire logic [6:0] io_oe_n,
	// far side drive
	input wire logic [6:0] ext_lvl,
	// resolved pin level
	output logic [6:0] io_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// device wins where it drives
	assign io_in = (io_oe_n & ext_lvl) | (~io_oe_n & io_out);
endmodule
